// ==== rtl/jsr_readback_host.sv ====
// Functional notes
// RQ1 - Idle in Run-Test/Idle twelve cycles, TMS low.
// RQ2 - Two high, two low to Shift-IR.
// RQ3 - Load input instruction, last bit exits.
// RQ4 - Two high, two low to Shift-DR.
// RQ5 - Shift eleven packet words, MSB first.
// RQ6 - 351 low cycles, last bit with TMS high.
// RQ7 - Three high, two low to Shift-IR.
// RQ8 - Load output instruction, last bit exits.
// RQ9 - Read bits with TMS low, count minus one.
// RQ10 - Final read bit taken with TMS high once.
// RQ11 - Select-IR, Shift-IR, then three high to reset.
// RQ12 - Discard the first dummy readback frame.
// RQ13 - Device drops done during shutdown.
// RQ14 - Drive TDI low when it is don't-care.
`timescale 1ns/1ns
`default_nettype none

module jsr_readback_host #(
    // Half period of tck in mclk cycles; at least three for the TDO synchroniser.
    parameter int          TCK_HALF    = jsr_pkg::TCK_HALF_CYC,
    // Words to read, taken from the count header by default.
    parameter logic [31:0] RB_WORDS    = 32'(jsr_pkg::COUNT_HEADER[jsr_pkg::COUNT_FIELD_BITS-1:0]),
    // Dummy words dropped ahead of real frame data; must stay below RB_WORDS.
    parameter logic [31:0] FRAME_WORDS = 32'h00000001
) (
    // Clock, reset and the request to begin a walk.
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        start,
    // Test port pins; tdo arrives from the device's side and is not timed to mclk.
    input  wire logic        tdo,
    output logic             tck,
    output logic             tms,
    output logic             tdi,
    // Status and readback words for the user side.
    output logic             busy,
    output logic             done,
    output logic [31:0]      rbWord,
    output logic             rbValid
);

    // Derived counts. The read length is fixed when the block is built, so a host
    // that wants a different frame range needs a different instance. The count
    // header it shifts is a package constant and does not follow RB_WORDS, so a
    // shorter read simply stops early and leaves the rest of the frames unread.
    // DIV_LAST closes one half period of the test clock.
    localparam logic [31:0] RB_BITS      = 32'(RB_WORDS * jsr_pkg::WORD_BITS);
    localparam logic [31:0] DISCARD_BITS = 32'(FRAME_WORDS * jsr_pkg::WORD_BITS);
    localparam logic [7:0]  DIV_LAST     = 8'(TCK_HALF - 1);
    localparam logic [4:0]  WORD_LAST    = 5'(jsr_pkg::WORD_BITS - 1);

    // Whole state of the sequencer: the registered copy and the value it takes at the
    // next edge of mclk.
    jsr_pkg::jsr_regs_s r_reg;
    jsr_pkg::jsr_regs_s r_next;

    // TMS level held through each step. Every exit step carries TMS high together with
    // its last data bit, so the shift state is left on the very bit that completes the
    // register; a separate exit clock would push one bit too many.
    function automatic logic stepTms(input logic [4:0] s);
        logic v;
        v = 1'b0;
        unique case (s)
            jsr_pkg::ST_IDLE_WAIT:  v = 1'b0;   // RQ1
            jsr_pkg::ST_SEL_IR_A:   v = 1'b1;   // RQ2
            jsr_pkg::ST_SHIFT_IR_A: v = 1'b0;   // RQ2
            jsr_pkg::ST_IR_IN:      v = 1'b0;   // RQ3
            jsr_pkg::ST_IR_IN_MSB:  v = 1'b1;   // RQ3
            jsr_pkg::ST_SEL_DR_A:   v = 1'b1;   // RQ4
            jsr_pkg::ST_SHIFT_DR_A: v = 1'b0;   // RQ4
            jsr_pkg::ST_PKT:        v = 1'b0;   // RQ6
            jsr_pkg::ST_PKT_LSB:    v = 1'b1;   // RQ6
            jsr_pkg::ST_SEL_IR_B:   v = 1'b1;   // RQ7
            jsr_pkg::ST_SHIFT_IR_B: v = 1'b0;   // RQ7
            jsr_pkg::ST_IR_OUT:     v = 1'b0;   // RQ8
            jsr_pkg::ST_IR_OUT_MSB: v = 1'b1;   // RQ8
            jsr_pkg::ST_SEL_DR_B:   v = 1'b1;   // RQ4
            jsr_pkg::ST_SHIFT_DR_B: v = 1'b0;   // RQ4
            jsr_pkg::ST_READ:       v = 1'b0;   // RQ9
            jsr_pkg::ST_READ_LAST:  v = 1'b1;   // RQ10
            jsr_pkg::ST_SEL_IR_C:   v = 1'b1;   // RQ11
            jsr_pkg::ST_SHIFT_IR_C: v = 1'b0;   // RQ11
            jsr_pkg::ST_TLR:        v = 1'b1;   // RQ11
            default: begin
                // Unused step codes are never reached; low is a harmless level.
                v = 1'b0;
            end
        endcase
        return v;
    endfunction

    // Number of test clock cycles spent in each step. The counter is as wide as the
    // read length so that a full frame range fits in it; exit steps fall to the
    // default of one cycle, which is where TMS goes high with the last bit.
    // A read length of one bit would leave the read step empty and is not supported.
    function automatic logic [31:0] stepLen(input logic [4:0] s);
        logic [31:0] n;
        n = 32'(jsr_pkg::EXIT_CYC);
        unique case (s)
            jsr_pkg::ST_IDLE_WAIT:  n = 32'(jsr_pkg::IDLE_WAIT_CYC);   // RQ1
            jsr_pkg::ST_SEL_IR_A:   n = 32'(jsr_pkg::TO_SELECT_CYC);   // RQ2
            jsr_pkg::ST_SHIFT_IR_A: n = 32'(jsr_pkg::TO_SHIFT_CYC);    // RQ2
            jsr_pkg::ST_IR_IN:      n = 32'(jsr_pkg::IR_LOW_BITS);     // RQ3
            jsr_pkg::ST_SEL_DR_A:   n = 32'(jsr_pkg::TO_SELECT_CYC);   // RQ4
            jsr_pkg::ST_SHIFT_DR_A: n = 32'(jsr_pkg::TO_SHIFT_CYC);    // RQ4
            jsr_pkg::ST_PKT:        n = 32'(jsr_pkg::PKT_LOW_BITS);    // RQ6
            jsr_pkg::ST_SEL_IR_B:   n = 32'(jsr_pkg::TO_SEL_IR_CYC);   // RQ7
            jsr_pkg::ST_SHIFT_IR_B: n = 32'(jsr_pkg::TO_SHIFT_CYC);    // RQ7
            jsr_pkg::ST_IR_OUT:     n = 32'(jsr_pkg::IR_LOW_BITS);     // RQ8
            jsr_pkg::ST_SEL_DR_B:   n = 32'(jsr_pkg::TO_SELECT_CYC);   // RQ4
            jsr_pkg::ST_SHIFT_DR_B: n = 32'(jsr_pkg::TO_SHIFT_CYC);    // RQ4
            jsr_pkg::ST_READ:       n = RB_BITS - 32'h00000001;        // RQ9
            jsr_pkg::ST_SEL_IR_C:   n = 32'(jsr_pkg::TO_SEL_IR_CYC);   // RQ11
            jsr_pkg::ST_SHIFT_IR_C: n = 32'(jsr_pkg::TO_SHIFT_CYC);    // RQ11
            jsr_pkg::ST_TLR:        n = 32'(jsr_pkg::TO_TLR_CYC);      // RQ11
            default: begin
                n = 32'(jsr_pkg::EXIT_CYC);                            // RQ10
            end
        endcase
        return n;
    endfunction

    // Packet stream word by position. Positions past the count header are the two
    // flushing no-operation words; the device does nothing with them, but they push
    // the read request through its packet buffer before the instruction changes.
    // The position is the bit index divided by the word width.
    function automatic logic [31:0] packetWord(input logic [3:0] i);
        logic [31:0] w;
        w = jsr_pkg::NO_OPERATION_WORD;
        unique case (i)
            4'h0: w = jsr_pkg::DUMMY_WORD;
            4'h1: w = jsr_pkg::SYNC_WORD;
            4'h2: w = jsr_pkg::NO_OPERATION_WORD;
            4'h3: w = jsr_pkg::CMD_HEADER;
            4'h4: w = jsr_pkg::READBACK_CONFIG_COMMAND;
            4'h5: w = jsr_pkg::ADDR_HEADER;
            4'h6: w = jsr_pkg::START_ADDRESS;
            4'h7: w = jsr_pkg::READOUT_HEADER;
            4'h8: w = jsr_pkg::COUNT_HEADER;
            default: begin
                w = jsr_pkg::NO_OPERATION_WORD;
            end
        endcase
        return w;
    endfunction

    // TDI level for a given step and bit position within it. Instruction bits go out
    // least significant first, packet words most significant first; every other step
    // drives low so the pin never wanders while its value does not matter.
    function automatic logic tdiBit(input logic [4:0] s, input logic [31:0] b);
        logic        v;
        logic [8:0]  idx;
        logic [31:0] w;
        v   = 1'b0;                                                    // RQ14
        idx = 9'(b);
        w   = 32'h00000000;
        unique case (s)
            jsr_pkg::ST_IR_IN:      v = jsr_pkg::CFG_IN_INSTR[idx[2:0]];   // RQ3
            jsr_pkg::ST_IR_IN_MSB:  v = jsr_pkg::CFG_IN_INSTR[jsr_pkg::IR_MSB];
            jsr_pkg::ST_IR_OUT:     v = jsr_pkg::CFG_OUT_INSTR[idx[2:0]];  // RQ8
            jsr_pkg::ST_IR_OUT_MSB: v = jsr_pkg::CFG_OUT_INSTR[jsr_pkg::IR_MSB];
            jsr_pkg::ST_PKT, jsr_pkg::ST_PKT_LSB: begin
                // The exit step carries the very last bit of the stream, which is the
                // least significant bit of the second flushing word.
                if (s == jsr_pkg::ST_PKT_LSB) begin
                    idx = 9'(jsr_pkg::PKT_LOW_BITS);                    // RQ6
                end
                w = packetWord(idx[8:5]);
                v = w[~idx[4:0]];                                       // RQ5
            end
            default: begin
                v = 1'b0;                                               // RQ14
            end
        endcase
        return v;
    endfunction

    // Appends one received bit below the bits already held; the first bit of a word
    // thus ends up in bit 31.
    function automatic logic [31:0] shiftIn(input logic [31:0] w, input logic b);
        return {w[30:0], b};
    endfunction

    // Sequencer: divides mclk into the test clock, changes TMS and TDI on falling
    // edges and samples TDO on rising edges, when it has been stable half a period.
    // One walk, in test clock cycles:
    //   idle wait 12, to Select-IR 2, to Shift-IR 2, input instruction 5 + 1,
    //   to Select-DR 2, to Shift-DR 2, packet stream 351 + 1, to Select-IR 3,
    //   to Shift-IR 2, output instruction 5 + 1, to Select-DR 2, to Shift-DR 2,
    //   readback RB_BITS - 1 + 1, to Select-IR 3, to Shift-IR 2, to reset 3.
    // The step counter advances on the rise that consumes the last bit of a step,
    // so the following fall already presents the first bit of the next step.
    // TDO passes two flip-flops; with a half period of at least three mclk cycles
    // the synchronised copy is settled before the rise that samples it.
    // A start while busy is ignored. Only reset cuts a walk short, and the device's
    // port then stays in whatever state the walk had reached, since tck stops too.
    // The strobe for a finished word lasts one mclk cycle.
    always_comb begin
        r_next         = r_reg;
        r_next.rbValid = 1'b0;
        // Two-flop synchroniser for TDO; only tdoSync is read by the shift logic.
        r_next.tdoMeta = tdo;
        r_next.tdoSync = r_reg.tdoMeta;
        // Idle waits for start; run and park share the divider.
        unique case (r_reg.state)
            jsr_pkg::JSR_IDLE: begin
                // A start seeds the first step; TMS goes low for the idle wait at once.
                if (start) begin
                    r_next.state  = jsr_pkg::JSR_RUN;
                    r_next.step   = jsr_pkg::ST_IDLE_WAIT;
                    r_next.bitCnt = 32'h00000000;
                    r_next.rbCnt  = 32'h00000000;
                    r_next.div    = 8'h00;
                    r_next.tck    = 1'b0;
                    r_next.tms    = stepTms(jsr_pkg::ST_IDLE_WAIT);     // RQ1
                    r_next.tdi    = 1'b0;                               // RQ14
                    r_next.busy   = 1'b1;
                    r_next.done   = 1'b0;
                end
            end
            jsr_pkg::JSR_RUN, jsr_pkg::JSR_PARK: begin
                if (r_reg.div == DIV_LAST) begin
                    r_next.div = 8'h00;
                    r_next.tck = ~r_reg.tck;
                    if (!r_reg.tck && r_reg.state == jsr_pkg::JSR_RUN) begin
                        // Rising edge: the current bit is consumed. TMS and TDI were set
                        // half a period ago and TDO has had time to pass the synchroniser.
                        if (r_reg.step == jsr_pkg::ST_READ || r_reg.step == jsr_pkg::ST_READ_LAST) begin
                            r_next.shiftW = shiftIn(r_reg.shiftW, r_reg.tdoSync);           // RQ9
                            r_next.rbCnt  = r_reg.rbCnt + 32'h00000001;
                            // Words inside the dummy frame never reach the user side; the
                            // device fills its frame buffer with them before real data.
                            if (r_reg.rbCnt[4:0] == WORD_LAST && r_reg.rbCnt >= DISCARD_BITS) begin
                                r_next.rbWord  = shiftIn(r_reg.shiftW, r_reg.tdoSync);      // RQ12
                                r_next.rbValid = 1'b1;
                            end
                        end
                        // Step bookkeeping: move on after the last cycle of the current step.
                        if (r_reg.bitCnt == stepLen(r_reg.step) - 32'h00000001) begin
                            r_next.bitCnt = 32'h00000000;
                            if (r_reg.step == jsr_pkg::ST_TLR) begin
                                r_next.state = jsr_pkg::JSR_PARK;                            // RQ11
                            end else begin
                                r_next.step = r_reg.step + 5'h01;
                            end
                        end else begin
                            r_next.bitCnt = r_reg.bitCnt + 32'h00000001;
                        end
                    end else if (r_reg.tck) begin
                        // Falling edge: present the next bit, so that it has a full half
                        // period to settle at the device before the rise that takes it.
                        if (r_reg.state == jsr_pkg::JSR_PARK) begin
                            // Last fall of the walk: hand the sequence back to the user side.
                            r_next.state = jsr_pkg::JSR_IDLE;
                            r_next.busy  = 1'b0;
                            r_next.done  = 1'b1;
                            r_next.tdi   = 1'b0;                                             // RQ14
                        end else begin
                            r_next.tms = stepTms(r_reg.step);                                // RQ10
                            r_next.tdi = tdiBit(r_reg.step, r_reg.bitCnt);
                        end
                    end
                end else begin
                    // Between edges of tck the divider just counts.
                    r_next.div = r_reg.div + 8'h01;
                end
            end
            default: begin
                // An illegal state code returns to idle rather than driving the port.
                r_next.state = jsr_pkg::JSR_IDLE;
                r_next.busy  = 1'b0;
            end
        endcase
    end

    // Register bank; TMS rests high so the port stays in Test-Logic-Reset when idle.
    // Reset is synchronous: a mid-run reset stops the test clock low at the next edge
    // of mclk, which the device sees as a clock that simply stops.
    // The divider and counters restart from zero with the next start.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r_reg       <= '0;
            r_reg.state <= jsr_pkg::JSR_IDLE;
            r_reg.tms   <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs come directly from the register bank, so no pin carries a combinational
    // path from start or tdo, and every pin changes only on an edge of mclk.
    assign tck     = r_reg.tck;
    assign tms     = r_reg.tms;
    assign tdi     = r_reg.tdi;
    assign busy    = r_reg.busy;
    assign done    = r_reg.done;
    assign rbWord  = r_reg.rbWord;
    assign rbValid = r_reg.rbValid;

endmodule

`default_nettype wire

// ==== rtl/jsr_pkg.sv ====
// Constants and state types for the shutdown readback test-port sequencer.
package jsr_pkg;

    // Clock rates; the test clock is made here by dividing mclk.
    localparam int MCLK_PERIOD_NS = 8;
    localparam int TCK_PERIOD_NS  = 80;
    localparam int TCK_HALF_CYC   = (TCK_PERIOD_NS / (2 * MCLK_PERIOD_NS) < 1) ? 1 :
                                    TCK_PERIOD_NS / (2 * MCLK_PERIOD_NS);

    // Instruction codes, six bits, shifted least significant bit first.
    localparam logic [5:0] CFG_IN_INSTR  = 6'h05;
    localparam logic [5:0] CFG_OUT_INSTR = 6'h04;
    localparam int         IR_LOW_BITS   = 5;
    localparam int         IR_MSB        = 5;

    // Cycle counts of the fixed walks through the state graph.
    localparam int IDLE_WAIT_CYC  = 12;
    localparam int TO_SELECT_CYC  = 2;
    localparam int TO_SHIFT_CYC   = 2;
    localparam int TO_SEL_IR_CYC  = 3;
    localparam int TO_TLR_CYC     = 3;
    localparam int EXIT_CYC       = 1;
    localparam int PKT_LOW_BITS   = 351;
    localparam int WORD_BITS      = 32;

    // Packet stream words, in shift order.
    localparam logic [31:0] DUMMY_WORD              = 32'hFFFFFFFF;
    localparam logic [31:0] SYNC_WORD               = 32'hAA995566;
    localparam logic [31:0] NO_OPERATION_WORD       = 32'h20000000;
    localparam logic [31:0] CMD_HEADER              = 32'h30008001;
    localparam logic [31:0] READBACK_CONFIG_COMMAND = 32'h00000004;
    localparam logic [31:0] ADDR_HEADER             = 32'h30002001;
    localparam logic [31:0] START_ADDRESS           = 32'h00000000;
    localparam logic [31:0] READOUT_HEADER          = 32'h28006000;
    localparam logic [31:0] COUNT_HEADER            = 32'h48024090;
    localparam int          COUNT_FIELD_BITS        = 27;

    // Step numbers of the sequence.
    localparam logic [4:0] ST_IDLE_WAIT  = 5'h00;
    localparam logic [4:0] ST_SEL_IR_A   = 5'h01;
    localparam logic [4:0] ST_SHIFT_IR_A = 5'h02;
    localparam logic [4:0] ST_IR_IN      = 5'h03;
    localparam logic [4:0] ST_IR_IN_MSB  = 5'h04;
    localparam logic [4:0] ST_SEL_DR_A   = 5'h05;
    localparam logic [4:0] ST_SHIFT_DR_A = 5'h06;
    localparam logic [4:0] ST_PKT        = 5'h07;
    localparam logic [4:0] ST_PKT_LSB    = 5'h08;
    localparam logic [4:0] ST_SEL_IR_B   = 5'h09;
    localparam logic [4:0] ST_SHIFT_IR_B = 5'h0A;
    localparam logic [4:0] ST_IR_OUT     = 5'h0B;
    localparam logic [4:0] ST_IR_OUT_MSB = 5'h0C;
    localparam logic [4:0] ST_SEL_DR_B   = 5'h0D;
    localparam logic [4:0] ST_SHIFT_DR_B = 5'h0E;
    localparam logic [4:0] ST_READ       = 5'h0F;
    localparam logic [4:0] ST_READ_LAST  = 5'h10;
    localparam logic [4:0] ST_SEL_IR_C   = 5'h11;
    localparam logic [4:0] ST_SHIFT_IR_C = 5'h12;
    localparam logic [4:0] ST_TLR        = 5'h13;

    typedef enum logic [2:0] {
        JSR_IDLE = 3'h1,
        JSR_RUN  = 3'h2,
        JSR_PARK = 3'h4
    } jsr_state_e;

    typedef struct packed {
        jsr_state_e  state;
        logic [4:0]  step;
        logic [31:0] bitCnt;
        logic [7:0]  div;
        logic        tck;
        logic        tms;
        logic        tdi;
        logic        tdoMeta;
        logic        tdoSync;
        logic [31:0] rbCnt;
        logic [31:0] shiftW;
        logic [31:0] rbWord;
        logic        rbValid;
        logic        busy;
        logic        done;
    } jsr_regs_s;

endpackage

// ==== bench/jsr_readback_host_sva.sv ====
`timescale 1ns/1ns
`default_nettype none

module jsr_readback_host_chk #(
    parameter int TCK_HALF = 5
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        start,
    input wire logic        tdo,
    input wire logic        tck,
    input wire logic        tms,
    input wire logic        tdi,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [31:0] rbWord,
    input wire logic        rbValid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Counts the high phase of the test clock, so a divider slip shows up at the next fall.
    logic [7:0] hiCnt;
    always_ff @(posedge mclk) begin
        hiCnt <= (!rst_n || !tck) ? 8'h00 : hiCnt + 8'h01;
    end

    a_tck_phase: assert property ($fell(tck) |-> hiCnt == 8'(TCK_HALF))
        else $error("test clock high phase has the wrong length");
    a_link_stable: assert property ($rose(tck) |-> $stable(tms) && $stable(tdi))
        else $error("tms or tdi moved at a test clock rise");
    a_start_taken: assert property (start && !busy |=> busy && !tms && !tck)
        else $error("start while idle did not begin the sequence");
    a_idle_quiet: assert property (!busy |-> !tck && tms && !rbValid)
        else $error("link not parked while idle");
    a_tdi_idle: assert property (!busy |-> !tdi)
        else $error("tdi not low while idle");
    a_busy_done: assert property (!(busy && done))
        else $error("busy and done together");
    a_end_done: assert property ($fell(busy) |-> done)
        else $error("sequence ended without done");
    a_rb_pulse: assert property (rbValid |=> !rbValid)
        else $error("readback strobe longer than one cycle");
    a_rb_timing: assert property (rbValid |-> busy && $rose(tck))
        else $error("readback strobe outside a read rise");

    cover property (rbValid);
    cover property ($fell(busy));
    cover property (start && busy);
endmodule

bind jsr_readback_host jsr_readback_host_chk #(.TCK_HALF(TCK_HALF)) chk (.mclk(mclk), .rst_n(rst_n),
    .start(start), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .busy(busy), .done(done),
    .rbWord(rbWord), .rbValid(rbValid));

`default_nettype wire

// ==== bench/jsr_dev_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module jsr_dev_model #(
    parameter int RB_BITS  = 128,
    parameter int RD_FIRST = 393
) (
    input  wire logic rst_n,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    output logic      tdo
);
    logic tmsLog [0:1023];
    logic tdiLog [0:1023];
    int   nRise;
    // The device's done output; every walk here runs after a shutdown, so it stays low.
    logic cfgDone;

    // Word zero is the dummy frame; later words carry their index so order slips are visible.
    function automatic logic rbBit(input int k);
        logic [31:0] w;
        w = {16'hA5C3, 16'(k / 32)};
        return w[31 - (k % 32)];
    endfunction

    // Logs every rise of the test clock; the bench replays the log against the sequence.
    always @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            nRise = 0;
            cfgDone = 1'b0;
        end else begin
            tmsLog[nRise] = tms;
            tdiLog[nRise] = tdi;
            nRise = nRise + 1;
        end
    end

    // Data leaves on the fall so it is settled at the host's next rise.
    // Outside the read window a real port floats, so the pin toggles to expose stale sampling.
    initial tdo = 1'b0;
    always @(negedge tck) begin
        if (nRise >= RD_FIRST && nRise < RD_FIRST + RB_BITS) begin
            tdo <= rbBit(nRise - RD_FIRST);
        end else begin
            tdo <= ~tdo;
        end
    end
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    localparam int RB_W    = 4;
    localparam int RB_BITS = RB_W * 32;

    logic        mclk, rst_n, start, tdo, tck, tms, tdi, busy, done, rbValid;
    logic [31:0] rbWord;
    logic [31:0] got [$];
    logic        expT [0:1023];
    logic        expD [0:1023];
    int          ne, miscompares, num_checks;

    jsr_readback_host #(.TCK_HALF(5), .RB_WORDS(32'(RB_W)), .FRAME_WORDS(32'h00000001)) dut (.mclk(mclk),
        .rst_n(rst_n), .start(start), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .busy(busy),
        .done(done), .rbWord(rbWord), .rbValid(rbValid));
    jsr_dev_model #(.RB_BITS(RB_BITS), .RD_FIRST(393)) dev (.rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Collects every delivered word for the end-of-run comparison.
    always @(posedge mclk) begin
        if (rbValid === 1'b1) got.push_back(rbWord);
    end

    task automatic chk_bit(input logic g, input logic e, input string m);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h expected %h", $time, m, g, e);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks: %0d, mismatches: %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic add(input logic t, input logic d, input int k);
        repeat (k) begin
            expT[ne] = t;
            expD[ne] = d;
            ne++;
        end
    endtask

    // Expected tms and tdi at every rise, written out from the sequence table.
    task automatic build_exp();
        logic [31:0] pkt [0:10];
        int w;
        int b;
        pkt = '{32'hFFFFFFFF, 32'hAA995566, 32'h20000000, 32'h30008001, 32'h00000004, 32'h30002001,
                32'h00000000, 32'h28006000, 32'h48024090, 32'h20000000, 32'h20000000};
        ne = 0;
        add(1'b0, 1'b0, 12);
        add(1'b1, 1'b0, 2);
        add(1'b0, 1'b0, 2);
        for (b = 0; b < 6; b++) add(b == 5, b == 0 || b == 2, 1);
        add(1'b1, 1'b0, 2);
        add(1'b0, 1'b0, 2);
        for (w = 0; w < 11; w++) for (b = 31; b >= 0; b--) add(w == 10 && b == 0, pkt[w][b], 1);
        add(1'b1, 1'b0, 3);
        add(1'b0, 1'b0, 2);
        for (b = 0; b < 6; b++) add(b == 5, b == 2, 1);
        add(1'b1, 1'b0, 2);
        add(1'b0, 1'b0, 2);
        for (b = 0; b < RB_BITS; b++) add(b == RB_BITS - 1, 1'b0, 1);
        add(1'b1, 1'b0, 3);
        add(1'b0, 1'b0, 2);
        add(1'b1, 1'b0, 3);
    endtask

    task automatic sc_reset_values();
        chk_word(32'({tck, tms, tdi, busy, done, rbValid}), 32'h00000010, "parked link");
        chk_word(rbWord, 32'h00000000, "word after reset");
    endtask

    // One full sequence; with poke set, a start mid-run must be ignored and leave the trace intact.
    task automatic run_seq(input bit poke);
        int i;
        got.delete();
        @(posedge mclk);
        #1 start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        chk_bit(busy, 1'b1, "busy after start");
        if (poke) begin
            repeat (300) @(posedge mclk);
            #1 start = 1'b1;
            @(posedge mclk);
            #1 start = 1'b0;
        end
        for (i = 0; i < 20000 && done !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (i == 20000) begin
            miscompares++;
            tally_and_finish();
        end
        chk_bit(busy, 1'b0, "busy after end");
        chk_word(32'(dev.nRise), 32'(ne), "rise count");
        for (i = 0; i < ne; i++) begin
            chk_bit(dev.tmsLog[i], expT[i], "tms at rise");
            chk_bit(dev.tdiLog[i], expD[i], "tdi at rise");
        end
        chk_word(32'(got.size()), 32'(RB_W - 1), "word count");
        for (i = 0; i < got.size(); i++) chk_word(got[i], {16'hA5C3, 16'(i + 1)}, "readback word");
    endtask

    // Reset in mid-run must park the link at once, and a fresh run must then complete cleanly.
    task automatic sc_abort();
        @(posedge mclk);
        #1 start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        repeat (2000) @(posedge mclk);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        sc_reset_values();
        rst_n = 1'b1;
        run_seq(1'b0);
    endtask

    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        miscompares = 0;
        num_checks = 0;
        build_exp();
        repeat (6) @(posedge mclk);
        #1 rst_n = 1'b1;
        sc_reset_values();
        run_seq(1'b1);
        sc_abort();
        tally_and_finish();
    end
endmodule

`default_nettype wire
